//--- ged_cfg.svh
// constants of the edge-detect and alternate-select block
`ifndef GED_CFG_SVH
`define GED_CFG_SVH

// register byte offsets on the slave port
`define GED_ADDR_W        5
`define GED_OFF_RISE      5'h10
`define GED_OFF_FALL      5'h14
`define GED_OFF_STATUS    5'h18
`define GED_OFF_ALT       5'h1C

// field layout
`define GED_PIN_COUNT     28
`define GED_PIN_HI        27
`define GED_GROUP_LO      11
`define GED_GROUP_HI      27
`define GED_SINGLE_HI     10
`define GED_RSVD_ZERO     4'h0

// reset values
`define GED_EN_RESET      28'h0000003
`define GED_STAT_RESET    28'h0000000
`define GED_ALT_RESET     28'h0000000
`define GED_DATA_RESET    32'h00000000

// pins 1 and 0 never leave general-purpose use
`define GED_NO_ALT_MASK   28'h0000003

// cycles until the synchroniser holds real pin history
`define GED_PRIME_CYCLES  2'h3

`endif

//--- ged_pkg.sv
// types shared by the edge-detect and alternate-select block
`include "ged_cfg.svh"

package ged_pkg;

    // one bit per port pin
    typedef logic [`GED_PIN_HI:0] ged_pins_t;

    // slave port handshake phases
    typedef enum logic {
        ged_idle,
        ged_ack
    } ged_bus_state_t;

    // edge detector state
    typedef struct packed {
        ged_pins_t   sync1;
        ged_pins_t   sync2;
        ged_pins_t   prev;
        logic [1:0]  prime;
    } ged_edge_state_t;

    // main block state
    typedef struct packed {
        ged_bus_state_t bus;
        logic           waitreq;
        logic [31:0]    rdata;
        ged_pins_t      rise_en;
        ged_pins_t      fall_en;
        ged_pins_t      status;
        ged_pins_t      alt_sel;
        ged_pins_t      alt_route;
        logic           irq_group;
        logic           wake;
        ged_pins_t      pad_out;
        ged_pins_t      pad_oe;
    } ged_top_state_t;

endpackage

//--- ged_edge.sv
// pin synchroniser and per-pin edge detector
`timescale 1ns/1ps
`include "ged_cfg.svh"

module ged_edge (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // pins
    input  wire ged_pkg::ged_pins_t pin_in,
    // edge pulses
    output ged_pkg::ged_pins_t rise_out,
    output ged_pkg::ged_pins_t fall_out,
    output logic               primed_out
);

    ged_pkg::ged_edge_state_t r;
    ged_pkg::ged_edge_state_t next_r;

    // two-flop synchroniser, then one cycle of history
    always_comb begin
        next_r       = r;
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;
        next_r.prev  = r.sync2;
        if (r.prime != `GED_PRIME_CYCLES) begin
            next_r.prime = r.prime + 2'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // history is junk until prev holds a real sample, so no edges then
    assign primed_out = (r.prime == `GED_PRIME_CYCLES);
    assign rise_out   = primed_out ? (r.sync2 & ~r.prev) : '0;
    assign fall_out   = primed_out ? (~r.sync2 & r.prev) : '0;

endmodule // ged_edge

//--- ged_top.sv
// edge-detect status and alternate-select part of a 28-pin port
//
// Notes on behaviour
// - a low-to-high pin change sets its status bit when rising enable is one
// - a high-to-low pin change sets its status bit when falling enable is one
// - with both enables one, a change either way sets the status bit
// - each register holds 28 pin bits; bits 31 to 28 ignore writes, read zero
// - reset forces rising and falling enables of pins 1 and 0 to one
// - a set status bit stays set until software clears it
// - writing one clears a status bit; writing zero leaves it alone
// - status bits 27 to 11 are ORed into one grouped interrupt line
// - status bits 10 to 0 each drive their own interrupt line
// - status bits need no defined reset; reserved bits read zero
// - status bits reach the interrupt controller for interrupt or wake-up
// - an alternate-select bit of one hands the pin to its alternate function
// - an alternate-select bit of zero keeps the pin on general-purpose I/O
// - every reset clears all alternate-select bits
// - pins 0 and 1 have no alternate function; their select bits do nothing
// - registers sit at byte offsets 0x10, 0x14, 0x18 and 0x1C
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ged_cfg.svh"

module ged_top (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // register slave port
    input  wire logic [`GED_ADDR_W-1:0] avs_address_in,
    input  wire logic                 avs_read_in,
    input  wire logic                 avs_write_in,
    input  wire logic [31:0]          avs_writedata_in,
    input  wire logic [3:0]           avs_byteenable_in,
    output logic      [31:0]          avs_readdata_out,
    output logic                      avs_waitrequest_out,
    // pins and the two drivers that compete for them
    input  wire ged_pkg::ged_pins_t   pin_in,
    input  wire ged_pkg::ged_pins_t   gpio_out_in,
    input  wire ged_pkg::ged_pins_t   gpio_oe_in,
    input  wire ged_pkg::ged_pins_t   alt_out_in,
    input  wire ged_pkg::ged_pins_t   alt_oe_in,
    output ged_pkg::ged_pins_t        pad_out_out,
    output ged_pkg::ged_pins_t        pad_oe_out,
    output ged_pkg::ged_pins_t        alt_route_out,
    // interrupt controller
    output logic [`GED_SINGLE_HI:0]   irq_pin_out,
    output logic                      irq_group_out,
    output logic                      wake_out
);

    ged_pkg::ged_top_state_t r;
    ged_pkg::ged_top_state_t next_r;

    ged_pkg::ged_pins_t rise;
    ged_pkg::ged_pins_t fall;
    logic               primed;

    // helpers shared by logic and checks
    ged_pkg::ged_pins_t rise_hit;
    ged_pkg::ged_pins_t fall_hit;
    ged_pkg::ged_pins_t set_vec;
    ged_pkg::ged_pins_t clr_vec;
    ged_pkg::ged_pins_t status_q;
    ged_pkg::ged_pins_t route_exp;
    logic [31:0]        be_mask;
    logic [31:0]        read_word;
    logic               wr_commit;

    // pin synchroniser and edge finder
    ged_edge u_edge (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .pin_in     (pin_in),
        .rise_out   (rise),
        .fall_out   (fall),
        .primed_out (primed)
    );

    // edge qualification by the enables
    assign rise_hit = rise & r.rise_en;
    assign fall_hit = fall & r.fall_en;
    assign set_vec  = rise_hit | fall_hit;
    assign status_q = r.status;

    // byte lanes widened to a bit mask
    assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    // a write lands on the edge where the master sees waitrequest low
    assign wr_commit = avs_write_in && (r.bus == ged_pkg::ged_ack);

    // one-to-clear strobe for the status register
    assign clr_vec = (wr_commit && avs_address_in == `GED_OFF_STATUS)
                   ? (avs_writedata_in[`GED_PIN_HI:0] & be_mask[`GED_PIN_HI:0])
                   : '0;

    // routing the select bits may take, pins 1 and 0 masked out
    assign route_exp = r.alt_sel & ~`GED_NO_ALT_MASK;

    // read decode; unmapped offsets read zero
    always_comb begin
        read_word = `GED_DATA_RESET;
        if (avs_address_in == `GED_OFF_RISE) begin
            read_word = {`GED_RSVD_ZERO, r.rise_en};
        end else if (avs_address_in == `GED_OFF_FALL) begin
            read_word = {`GED_RSVD_ZERO, r.fall_en};
        end else if (avs_address_in == `GED_OFF_STATUS) begin
            read_word = {`GED_RSVD_ZERO, r.status};
        end else if (avs_address_in == `GED_OFF_ALT) begin
            read_word = {`GED_RSVD_ZERO, r.alt_sel};
        end
    end

    // next-state logic for the whole block
    always_comb begin
        next_r = r;
        // slave handshake: one wait cycle, then one answer cycle
        case (r.bus)
            ged_pkg::ged_idle: begin
                if (avs_read_in || avs_write_in) begin
                    next_r.bus     = ged_pkg::ged_ack;
                    next_r.waitreq = 1'b0;
                    next_r.rdata   = avs_read_in ? read_word : r.rdata;
                end
            end
            ged_pkg::ged_ack: begin
                next_r.bus     = ged_pkg::ged_idle;
                next_r.waitreq = 1'b1;
            end
            default: begin
                next_r.bus     = ged_pkg::ged_idle;
                next_r.waitreq = 1'b1;
            end
        endcase
        // writable registers, reserved bits never stored
        if (wr_commit) begin
            if (avs_address_in == `GED_OFF_RISE) begin
                next_r.rise_en = (r.rise_en & ~be_mask[`GED_PIN_HI:0])
                               | (avs_writedata_in[`GED_PIN_HI:0]
                                  & be_mask[`GED_PIN_HI:0]);
            end else if (avs_address_in == `GED_OFF_FALL) begin
                next_r.fall_en = (r.fall_en & ~be_mask[`GED_PIN_HI:0])
                               | (avs_writedata_in[`GED_PIN_HI:0]
                                  & be_mask[`GED_PIN_HI:0]);
            end else if (avs_address_in == `GED_OFF_ALT) begin
                next_r.alt_sel = (r.alt_sel & ~be_mask[`GED_PIN_HI:0])
                               | (avs_writedata_in[`GED_PIN_HI:0]
                                  & be_mask[`GED_PIN_HI:0]);
            end
        end
        // sticky status: a new edge beats a clear in the same cycle
        next_r.status    = (r.status & ~clr_vec) | set_vec;
        // grouped line and wake request follow the new status
        next_r.irq_group = |next_r.status[`GED_GROUP_HI:`GED_GROUP_LO];
        next_r.wake      = |next_r.status;
        // pin ownership follows the select bits
        next_r.alt_route = route_exp;
        next_r.pad_out   = (r.alt_route & alt_out_in) | (~r.alt_route & gpio_out_in);
        next_r.pad_oe    = (r.alt_route & alt_oe_in) | (~r.alt_route & gpio_oe_in);
    end

    // state register; status gets a defined value though none is owed
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r           <= '0;
            r.bus       <= ged_pkg::ged_idle;
            r.waitreq   <= 1'b1;
            r.rise_en   <= `GED_EN_RESET;
            r.fall_en   <= `GED_EN_RESET;
            r.status    <= `GED_STAT_RESET;
            r.alt_sel   <= `GED_ALT_RESET;
            r.alt_route <= `GED_ALT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign avs_readdata_out    = r.rdata;
    assign avs_waitrequest_out = r.waitreq;
    assign irq_pin_out         = r.status[`GED_SINGLE_HI:0];
    assign irq_group_out       = r.irq_group;
    assign wake_out            = r.wake;
    assign alt_route_out       = r.alt_route;
    assign pad_out_out         = r.pad_out;
    assign pad_oe_out          = r.pad_oe;

    // ---- checks ----
    default clocking ged_cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // request seen while waiting, answered on the next cycle
    sequence s_req_waiting;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence

    sequence s_answer_once;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    a_bus_answer_timing: assert property (
        s_req_waiting |=> s_answer_once)
        else $error("slave answer not one wait cycle then one ack cycle");

    a_status_read_back: assert property (
        (avs_read_in && avs_waitrequest_out
         && avs_address_in == `GED_OFF_STATUS)
        |=> avs_readdata_out == {`GED_RSVD_ZERO, $past(status_q)})
        else $error("status read did not return status bits");

    a_reserved_reads_zero: assert property (
        !avs_waitrequest_out |-> avs_readdata_out[31:28] == `GED_RSVD_ZERO)
        else $error("reserved read bits not zero");

    a_rise_sets_status: assert property (
        (rise_hit != '0) |=> ((status_q & $past(rise_hit)) == $past(rise_hit)))
        else $error("enabled rising edge did not set status");

    a_fall_sets_status: assert property (
        (fall_hit != '0) |=> ((status_q & $past(fall_hit)) == $past(fall_hit)))
        else $error("enabled falling edge did not set status");

    a_disabled_edge_quiet: assert property (
        (status_q == '0 && set_vec == '0) |=> status_q == '0)
        else $error("status set without an enabled edge");

    a_status_sticky: assert property (
        ((($past(status_q) & ~status_q) & ~$past(clr_vec)) == '0))
        else $error("status bit dropped without a clear");

    a_one_clears_status: assert property (
        ((clr_vec & ~set_vec) != '0)
        |=> ((status_q & $past(clr_vec) & ~$past(set_vec)) == '0))
        else $error("write of one did not clear status");

    a_group_line_or: assert property (
        irq_group_out == |status_q[`GED_GROUP_HI:`GED_GROUP_LO])
        else $error("grouped interrupt not the OR of its bits");

    a_single_lines: assert property (
        irq_pin_out == status_q[`GED_SINGLE_HI:0])
        else $error("single interrupt lines differ from status");

    a_wake_follows: assert property (
        wake_out == (status_q != '0))
        else $error("wake request does not track status");

    a_enable_reset_value: assert property (
        @(posedge clk_in) $past(rst_in)
        |-> (r.rise_en[1:0] == 2'h3 && r.fall_en[1:0] == 2'h3))
        else $error("pin 1 and 0 enables not one after reset");

    a_alt_reset_clear: assert property (
        @(posedge clk_in) $past(rst_in) |-> (r.alt_sel == '0 && alt_route_out == '0))
        else $error("alternate select not clear after reset");

    a_low_pins_no_alt: assert property (
        alt_route_out[1:0] == 2'h0)
        else $error("pin 1 or 0 routed to an alternate function");

    a_route_follows_sel: assert property (
        1'b1 |=> alt_route_out == ($past(route_exp)))
        else $error("routing did not follow the select bits");

    a_pad_gpio_owner: assert property (
        (alt_route_out[2] == 1'b0) |=> pad_out_out[2] == $past(gpio_out_in[2]))
        else $error("general-purpose pin not driven by the port");

    a_pin_edge_found: assert property (
        (primed && $rose(pin_in[2]) ##1 pin_in[2]) |=> rise[2])
        else $error("pin rise not seen two cycles later");

    // register writes land whole, reserved bits never stored
    a_rise_write_lands: assert property (
        (wr_commit && avs_address_in == `GED_OFF_RISE && avs_byteenable_in == 4'hF)
        |=> r.rise_en == $past(avs_writedata_in[`GED_PIN_HI:0]))
        else $error("rising enable write did not land");

    a_fall_write_lands: assert property (
        (wr_commit && avs_address_in == `GED_OFF_FALL && avs_byteenable_in == 4'hF)
        |=> r.fall_en == $past(avs_writedata_in[`GED_PIN_HI:0]))
        else $error("falling enable write did not land");

    a_alt_write_lands: assert property (
        (wr_commit && avs_address_in == `GED_OFF_ALT && avs_byteenable_in == 4'hF)
        |=> r.alt_sel == $past(avs_writedata_in[`GED_PIN_HI:0]))
        else $error("alternate select write did not land");

    a_regs_hold_idle: assert property (
        !wr_commit |=> ($stable(r.rise_en) && $stable(r.fall_en) && $stable(r.alt_sel)))
        else $error("control register changed without a write");

    // each mapped register reads back its own bits
    a_rise_read_back: assert property (
        (avs_read_in && avs_waitrequest_out && avs_address_in == `GED_OFF_RISE)
        |=> avs_readdata_out == {`GED_RSVD_ZERO, $past(r.rise_en)})
        else $error("rising enable read did not return its bits");

    a_fall_read_back: assert property (
        (avs_read_in && avs_waitrequest_out && avs_address_in == `GED_OFF_FALL)
        |=> avs_readdata_out == {`GED_RSVD_ZERO, $past(r.fall_en)})
        else $error("falling enable read did not return its bits");

    a_alt_read_back: assert property (
        (avs_read_in && avs_waitrequest_out && avs_address_in == `GED_OFF_ALT)
        |=> avs_readdata_out == {`GED_RSVD_ZERO, $past(r.alt_sel)})
        else $error("alternate select read did not return its bits");

    a_unmapped_reads_zero: assert property (
        (avs_read_in && avs_waitrequest_out
         && avs_address_in != `GED_OFF_RISE && avs_address_in != `GED_OFF_FALL
         && avs_address_in != `GED_OFF_STATUS && avs_address_in != `GED_OFF_ALT)
        |=> avs_readdata_out == `GED_DATA_RESET)
        else $error("unmapped read did not return zero");

    // read data only moves on a read answer, so a slow master still sees it
    a_readdata_held: assert property (
        !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
        else $error("read data changed without a read answer");

    a_idle_keeps_waiting: assert property (
        (!avs_read_in && !avs_write_in && avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest dropped with no request");

    // a status bit only appears behind an enabled edge
    a_set_needs_edge: assert property (
        1'b1 |=> ((status_q & ~$past(status_q) & ~$past(set_vec)) == '0))
        else $error("status bit set without an enabled edge");

    a_status_reset_zero: assert property (
        @(posedge clk_in) $past(rst_in) |-> (status_q == '0 && irq_group_out == 1'b0))
        else $error("status not cleared by reset");

    // pad mux ownership on both sides of the select
    a_pad_alt_owner: assert property (
        alt_route_out[2] |=> (pad_out_out[2] == $past(alt_out_in[2])
                              && pad_oe_out[2] == $past(alt_oe_in[2])))
        else $error("alternate pin not driven by its function");

    a_pad_gpio_enable: assert property (
        (alt_route_out[2] == 1'b0) |=> pad_oe_out[2] == $past(gpio_oe_in[2]))
        else $error("general-purpose pin enable not taken from the port");

    a_low_pins_gpio: assert property (
        1'b1 |=> (pad_out_out[1:0] == $past(gpio_out_in[1:0])
                  && pad_oe_out[1:0] == $past(gpio_oe_in[1:0])))
        else $error("pin 1 or 0 left general-purpose control");

    // select write, then routing two edges later
    sequence s_alt_written;
        wr_commit && avs_address_in == `GED_OFF_ALT && avs_byteenable_in == 4'hF;
    endsequence

    a_alt_route_path: assert property (
        s_alt_written |=> ##1 alt_route_out == ($past(avs_writedata_in[`GED_PIN_HI:0], 2)
                                                & ~`GED_NO_ALT_MASK))
        else $error("written select did not reach the routing");

endmodule // ged_top

//--- ged_pin_model.sv
// far-side model: external pins and the two drivers competing for them
`timescale 1ns/1ps

module ged_pin_model #(
    parameter logic [27:0] GPIO_V  = 28'hAAAAAAA,
    parameter logic [27:0] GPIO_EN = 28'hFFFFFFF,
    parameter logic [27:0] ALT_V   = 28'h5555555,
    parameter logic [27:0] ALT_EN  = 28'h0F0F0F0
) (
    // clock
    input  wire logic               clk_in,
    // wanted pin levels from the bench
    input  wire ged_pkg::ged_pins_t level_in,
    // pins and drivers
    output ged_pkg::ged_pins_t      pin_out,
    output ged_pkg::ged_pins_t      gpio_out_out,
    output ged_pkg::ged_pins_t      gpio_oe_out,
    output ged_pkg::ged_pins_t      alt_out_out,
    output ged_pkg::ged_pins_t      alt_oe_out
);
    // pins move only just after an edge, so each level lasts whole cycles
    always @(posedge clk_in) begin
        pin_out <= level_in;
    end
    // fixed, distinct patterns so a wrong mux choice shows
    assign gpio_out_out = GPIO_V;
    assign gpio_oe_out  = GPIO_EN;
    assign alt_out_out  = ALT_V;
    assign alt_oe_out   = ALT_EN;
endmodule // ged_pin_model

//--- gpio_edge_detect_altfunc_test.sv
// self-checking bench of the edge-detect and alternate-select block
`timescale 1ns/1ps
`include "ged_cfg.svh"

module gpio_edge_detect_altfunc_test;
    localparam logic [27:0] GV = 28'hAAAAAAA, GE = 28'hFFFFFFF;
    localparam logic [27:0] AV = 28'h5555555, AE = 28'h0F0F0F0;
    logic               clk_in = 1'b0;
    logic               rst_in = 1'b1;
    logic [4:0]         addr   = 5'h00;
    logic               rd     = 1'b0;
    logic               wr     = 1'b0;
    logic [31:0]        wdata  = 32'h00000000;
    logic [3:0]         be     = 4'hF;
    logic [31:0]        rdata, rv;
    logic               wreq;
    ged_pkg::ged_pins_t lvl = 28'h0000000;
    ged_pkg::ged_pins_t pin, go, ge, ao, ae, pad, pade, route;
    logic [10:0]        irq;
    logic               grp, wake;
    int                 fails = 0;
    int                 checks_done = 0;
    logic [27:0]        r;

    always #5 clk_in = ~clk_in;

    ged_pin_model #(.GPIO_V(GV), .GPIO_EN(GE), .ALT_V(AV), .ALT_EN(AE)) u_ged_pin_model (
        .clk_in(clk_in), .level_in(lvl), .pin_out(pin), .gpio_out_out(go),
        .gpio_oe_out(ge), .alt_out_out(ao), .alt_oe_out(ae));

    ged_top u_ged_top (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .pin_in(pin),
        .gpio_out_in(go), .gpio_oe_in(ge), .alt_out_in(ao), .alt_oe_in(ae),
        .pad_out_out(pad), .pad_oe_out(pade), .alt_route_out(route),
        .irq_pin_out(irq), .irq_group_out(grp), .wake_out(wake));

    // single verdict point
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        @(posedge clk_in);
        while (wreq !== 1'b0 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        // one idle edge so the next call never re-raises in this time step
        @(posedge clk_in);
        if (n >= 20) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rv);
    endtask

    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, rv);
        check(name, rv, exp);
    endtask

    task automatic do_reset;
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    // expected pad drive for a given routing
    task automatic chk_pads(input logic [27:0] rt);
        check("route", 32'(route), 32'(rt));
        check("pad_out", 32'(pad), 32'((AV & rt) | (GV & ~rt)));
        check("pad_oe", 32'(pade), 32'((AE & rt) | (GE & ~rt)));
    endtask

    initial begin
        do_reset();
        rd_chk("rise_rst", `GED_OFF_RISE, 32'h00000003);
        rd_chk("fall_rst", `GED_OFF_FALL, 32'h00000003);
        rd_chk("alt_rst", `GED_OFF_ALT, 32'h00000000);
        rd_chk("unmapped", 5'h04, 32'h00000000);
        // reserved bits dropped in both enable registers; status cleared
        wr_reg(`GED_OFF_RISE, 32'hFFFFFFFF);
        rd_chk("rise_rsvd", `GED_OFF_RISE, 32'h0FFFFFFF);
        be <= 4'h1;
        wr_reg(`GED_OFF_RISE, 32'h00000000);
        be <= 4'hF;
        rd_chk("rise_lane", `GED_OFF_RISE, 32'h0FFFFF00);
        wr_reg(`GED_OFF_FALL, 32'hFFFFFFFF);
        rd_chk("fall_rsvd", `GED_OFF_FALL, 32'h0FFFFFFF);
        wr_reg(`GED_OFF_STATUS, 32'hFFFFFFFF);
        rd_chk("stat_clr", `GED_OFF_STATUS, 32'h00000000);
        // pin 5 rising only, pin 12 falling only, pin 3 both, pin 2 neither
        wr_reg(`GED_OFF_RISE, 32'h00000028);
        wr_reg(`GED_OFF_FALL, 32'h00001008);
        lvl <= 28'h000102C;
        repeat (6) @(posedge clk_in);
        rd_chk("stat_rise", `GED_OFF_STATUS, 32'h00000028);
        check("irq_pins", 32'(irq), 32'h00000028);
        check("group_lo", 32'(grp), 32'h0);
        check("wake_on", 32'(wake), 32'h1);
        lvl <= 28'h0000000;
        repeat (6) @(posedge clk_in);
        rd_chk("stat_fall", `GED_OFF_STATUS, 32'h00001028);
        check("group_hi", 32'(grp), 32'h1);
        // zero writes leave bits, one writes clear them
        wr_reg(`GED_OFF_STATUS, 32'h00000000);
        rd_chk("stat_keep", `GED_OFF_STATUS, 32'h00001028);
        wr_reg(`GED_OFF_STATUS, 32'h00001000);
        rd_chk("stat_part", `GED_OFF_STATUS, 32'h00000028);
        check("group_clr", 32'(grp), 32'h0);
        // pin 3 rises again with both enables set
        wr_reg(`GED_OFF_STATUS, 32'h00000028);
        lvl <= 28'h0000008;
        repeat (6) @(posedge clk_in);
        rd_chk("stat_both", `GED_OFF_STATUS, 32'h00000008);
        wr_reg(`GED_OFF_STATUS, 32'h00000008);
        repeat (2) @(posedge clk_in);
        check("irq_clr", 32'(irq), 32'h00000000);
        check("wake_off", 32'(wake), 32'h0);
        // alternate routing, pins 1 and 0 excluded
        wr_reg(`GED_OFF_ALT, 32'hFFFFFFFF);
        rd_chk("alt_rsvd", `GED_OFF_ALT, 32'h0FFFFFFF);
        repeat (3) @(posedge clk_in);
        r = 28'hFFFFFFC;
        chk_pads(r);
        do_reset();
        rd_chk("alt_rst2", `GED_OFF_ALT, 32'h00000000);
        chk_pads(28'h0000000);
        wr_reg(`GED_OFF_ALT, 32'h00000013);
        repeat (3) @(posedge clk_in);
        chk_pads(28'h0000010);
        report_and_stop();
    end

    // hang guard
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule // gpio_edge_detect_altfunc_test
